//--- hw/bbls_core.sv
// Blanking timer, extension counter, spike delay and burst level detection.
`timescale 1ns/100ps
module bbls_core #(
   parameter logic [19:0] BLANK_CYC = 20'(bbls_pkg::BLANK_CYC),
   parameter logic [19:0] DETECT_CYC = 20'(bbls_pkg::DETECT_CYC),
   parameter logic [15:0] DET_BOUND_0 = bbls_pkg::DET_BOUND_0,
   parameter logic [15:0] DET_BOUND_1 = bbls_pkg::DET_BOUND_1,
   parameter logic [15:0] DET_BOUND_2 = bbls_pkg::DET_BOUND_2
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire bbls_pkg::bbls_cmp_type cmp,
   input wire logic vcc_on,
   input wire logic protect_hold,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output bbls_pkg::bbls_sw_type sw,
   output logic level_detect_ff,
   output logic protect_and_gate,
   output logic extend_done,
   output logic auto_restart,
   output logic burst_mode,
   output bbls_pkg::bbls_level_type level
);
   localparam logic [9:0] SPIKE_LAST = 10'(bbls_pkg::SPIKE_CYC - 1);

   // --------------------------------------------------------------
   // Register port
   // --------------------------------------------------------------
   logic extend_mode;
   logic [31:0] next_rdata;
   wire ctrl_hit = (addr == bbls_pkg::ADDR_CTRL);
   wire status_hit = (addr == bbls_pkg::ADDR_STATUS);
   wire count_hit = (addr == bbls_pkg::ADDR_COUNT);
   logic blank_done;
   logic det_done;
   logic [8:0] ext_cnt;
   logic [15:0] det_cnt;
   wire [31:0] status_word = {24'h000000, det_done, level.sel, burst_mode,
                              auto_restart, extend_done, blank_done, extend_mode};
   wire [31:0] count_word = {7'h00, ext_cnt, det_cnt};

   always_comb begin
      next_rdata = 32'h00000000;
      if (rd && ctrl_hit) begin
         next_rdata = {31'h00000000, extend_mode};
      end else if (rd && status_hit) begin
         next_rdata = status_word;
      end else if (rd && count_hit) begin
         next_rdata = count_word;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 32'h00000000;
         extend_mode <= bbls_pkg::CTRL_EXTEND_RESET;
      end else begin
         rdata <= next_rdata;
         if (wr && ctrl_hit) begin
            extend_mode <= wdata[bbls_pkg::CTRL_EXTEND_BIT];
         end
      end
   end

   // --------------------------------------------------------------
   // Overload blanking and extension
   // --------------------------------------------------------------
   logic [19:0] blank_cnt;
   bbls_pkg::bbls_ext_state_type ext_state;
   bbls_pkg::bbls_ext_state_type next_ext_state;
   logic [9:0] spike_cnt;
   wire blank_hit = cmp.overload_cmp && (blank_cnt == BLANK_CYC - 20'h00001);
   wire ext_count_up = (ext_state == bbls_pkg::EXT_CHARGE) && cmp.extend_upper_cmp;
   wire ext_last = ext_count_up && (ext_cnt == bbls_pkg::EXT_TOTAL - 9'h001);

   always_comb begin
      next_ext_state = ext_state;
      unique case (ext_state)
         bbls_pkg::EXT_IDLE: begin
            if (blank_done && extend_mode) begin
               next_ext_state = bbls_pkg::EXT_CHARGE;
            end
         end
         bbls_pkg::EXT_CHARGE: begin
            if (ext_last) begin
               next_ext_state = bbls_pkg::EXT_DONE;
            end else if (ext_count_up) begin
               next_ext_state = bbls_pkg::EXT_DISCHARGE;
            end
         end
         bbls_pkg::EXT_DISCHARGE: begin
            if (cmp.extend_lower_cmp) begin
               next_ext_state = bbls_pkg::EXT_CHARGE;
            end
         end
         bbls_pkg::EXT_DONE: begin
            next_ext_state = bbls_pkg::EXT_DONE;
         end
      endcase
      if (!cmp.overload_cmp) begin
         next_ext_state = bbls_pkg::EXT_IDLE;
      end
   end

   assign extend_done = (ext_state == bbls_pkg::EXT_DONE);
   assign protect_and_gate = blank_done && (extend_mode ? extend_done : 1'b1);
   assign sw.extend_charge_sw = (ext_state == bbls_pkg::EXT_CHARGE);
   assign sw.extend_discharge_sw = (ext_state == bbls_pkg::EXT_DISCHARGE);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         blank_cnt <= 20'h00000;
         blank_done <= 1'b0;
         ext_state <= bbls_pkg::EXT_IDLE;
         ext_cnt <= 9'h000;
         spike_cnt <= 10'h000;
         auto_restart <= 1'b0;
      end else begin
         ext_state <= next_ext_state;
         if (!cmp.overload_cmp) begin
            blank_cnt <= 20'h00000;
            blank_done <= 1'b0;
            ext_cnt <= 9'h000;
         end else begin
            if (!blank_done) begin
               blank_cnt <= blank_cnt + 20'h00001;
            end
            if (blank_hit) begin
               blank_done <= 1'b1;
            end
            if (ext_count_up) begin
               ext_cnt <= ext_cnt + 9'h001;
            end
         end
         if (protect_and_gate && !auto_restart) begin
            spike_cnt <= spike_cnt + 10'h001;
            if (spike_cnt == SPIKE_LAST) begin
               auto_restart <= 1'b1;
            end
         end else begin
            spike_cnt <= 10'h000;
         end
         if (!vcc_on) begin
            auto_restart <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------
   // Burst level detection
   // --------------------------------------------------------------
   bbls_pkg::bbls_det_state_type det_state;
   bbls_pkg::bbls_det_state_type next_det_state;
   logic [19:0] win_cnt;
   wire det_running = (det_state == bbls_pkg::DET_CHARGE) ||
                      (det_state == bbls_pkg::DET_DISCHARGE);
   wire win_end = det_running && (win_cnt == DETECT_CYC - 20'h00001);
   wire det_count_up = (det_state == bbls_pkg::DET_CHARGE) && cmp.fb_upper_cmp;
   wire det_fall = (det_state == bbls_pkg::DET_DISCHARGE) && cmp.fb_lower_cmp;

   function automatic logic [1:0] pick_sel(input logic [15:0] count);
      logic [1:0] sel;
      sel = bbls_pkg::SEL_NEVER;
      if (count <= DET_BOUND_0) begin
         sel = 2'h0;
      end else if (count <= DET_BOUND_1) begin
         sel = 2'h1;
      end else if (count <= DET_BOUND_2) begin
         sel = 2'h2;
      end
      return sel;
   endfunction

   always_comb begin
      next_det_state = det_state;
      unique case (det_state)
         bbls_pkg::DET_WAIT: begin
            if (vcc_on && !protect_hold) begin
               next_det_state = bbls_pkg::DET_CHARGE;
            end
         end
         bbls_pkg::DET_CHARGE: begin
            if (det_count_up) begin
               next_det_state = bbls_pkg::DET_DISCHARGE;
            end
         end
         bbls_pkg::DET_DISCHARGE: begin
            if (det_fall) begin
               next_det_state = bbls_pkg::DET_CHARGE;
            end
         end
         bbls_pkg::DET_DONE: begin
            next_det_state = bbls_pkg::DET_DONE;
         end
      endcase
      if (win_end) begin
         next_det_state = bbls_pkg::DET_DONE;
      end
   end

   assign det_done = (det_state == bbls_pkg::DET_DONE);
   assign sw.fb_discharge_sw = level_detect_ff;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         det_state <= bbls_pkg::DET_WAIT;
         win_cnt <= 20'h00000;
         det_cnt <= 16'h0000;
         level_detect_ff <= 1'b0;
         level.sel <= bbls_pkg::SEL_NEVER;
      end else begin
         det_state <= next_det_state;
         if (det_running) begin
            win_cnt <= win_cnt + 20'h00001;
         end
         if (det_count_up && !win_end) begin
            det_cnt <= det_cnt + 16'h0001;
            level_detect_ff <= 1'b1;
         end else if (det_fall || win_end) begin
            level_detect_ff <= 1'b0;
         end
         if (win_end) begin
            level.sel <= pick_sel(det_cnt);
         end
      end
   end

   assign level.burst_entry_threshold = (level.sel == 2'h0) ? bbls_pkg::ENTRY_MV_0 :
                                        (level.sel == 2'h1) ? bbls_pkg::ENTRY_MV_1 :
                                        (level.sel == 2'h2) ? bbls_pkg::ENTRY_MV_2 :
                                        bbls_pkg::MV_NONE;
   assign level.burst_climit = (level.sel == 2'h0) ? bbls_pkg::CLIMIT_MV_0 :
                               (level.sel == 2'h1) ? bbls_pkg::CLIMIT_MV_1 :
                               (level.sel == 2'h2) ? bbls_pkg::CLIMIT_MV_2 :
                               bbls_pkg::MV_NONE;

   // --------------------------------------------------------------
   // Burst entry blanking
   // --------------------------------------------------------------
   logic [19:0] burst_cnt;
   wire burst_allowed = det_done && (level.sel != bbls_pkg::SEL_NEVER);
   wire burst_counting = burst_allowed && !burst_mode && cmp.burst_entry_cmp;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         burst_cnt <= 20'h00000;
         burst_mode <= 1'b0;
      end else begin
         if (burst_counting) begin
            burst_cnt <= burst_cnt + 20'h00001;
         end else begin
            burst_cnt <= 20'h00000;
         end
         if (burst_counting && (burst_cnt == BLANK_CYC - 20'h00001)) begin
            burst_mode <= 1'b1;
         end else if (cmp.burst_exit_cmp) begin
            burst_mode <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   property p_ext_up;
      ext_count_up && !ext_last && cmp.overload_cmp |=>
         sw.extend_discharge_sw && !sw.extend_charge_sw && ext_cnt == $past(ext_cnt) + 9'h001;
   endproperty
   a_ext_up: assert property (p_ext_up) else $error("Extension step wrong.");

   property p_ext_down;
      sw.extend_discharge_sw && cmp.extend_lower_cmp && cmp.overload_cmp |=>
         sw.extend_charge_sw && !sw.extend_discharge_sw;
   endproperty
   a_ext_down: assert property (p_ext_down) else $error("Recharge missed.");

   property p_ext_total;
      extend_done |-> ext_cnt == bbls_pkg::EXT_TOTAL;
   endproperty
   a_ext_total: assert property (p_ext_total) else $error("Early completion.");

   property p_gate_closed;
      extend_mode && !extend_done |-> !protect_and_gate;
   endproperty
   a_gate_closed: assert property (p_gate_closed) else $error("Gate opened early.");

   property p_ext_start;
      $rose(blank_done) && extend_mode && cmp.overload_cmp |=> sw.extend_charge_sw;
   endproperty
   a_ext_start: assert property (p_ext_start) else $error("Charge not started.");

   property p_spike;
      $rose(auto_restart) |-> $past(protect_and_gate) && $past(spike_cnt) == SPIKE_LAST;
   endproperty
   a_spike: assert property (p_spike) else $error("Spike delay wrong.");

   property p_det_once;
      det_done |=> det_done && $stable(level.sel);
   endproperty
   a_det_once: assert property (p_det_once) else $error("Detection reran.");

   property p_det_hold;
      det_state == bbls_pkg::DET_WAIT && protect_hold |=> det_state == bbls_pkg::DET_WAIT;
   endproperty
   a_det_hold: assert property (p_det_hold) else $error("Detection not held.");

   property p_det_up;
      det_count_up && !win_end |=>
         level_detect_ff && sw.fb_discharge_sw && det_cnt == $past(det_cnt) + 16'h0001;
   endproperty
   a_det_up: assert property (p_det_up) else $error("Detect count wrong.");

   property p_det_fall;
      det_fall |=> !level_detect_ff && !sw.fb_discharge_sw;
   endproperty
   a_det_fall: assert property (p_det_fall) else $error("Discharge not ended.");

   property p_burst_clear;
      !cmp.burst_entry_cmp |=> burst_cnt == 20'h00000;
   endproperty
   a_burst_clear: assert property (p_burst_clear) else $error("Burst count kept.");

   property p_blank_time;
      $rose(blank_done) |-> $past(blank_cnt) == BLANK_CYC - 20'h00001;
   endproperty
   a_blank_time: assert property (p_blank_time) else $error("Blanking time wrong.");

   property p_win_end;
      win_end |=> det_done && !level_detect_ff;
   endproperty
   a_win_end: assert property (p_win_end) else $error("Detection not stopped.");

   property p_burst_entry;
      burst_counting && burst_cnt == BLANK_CYC - 20'h00001 |=> burst_mode;
   endproperty
   a_burst_entry: assert property (p_burst_entry) else $error("Burst not entered.");

   c_ext_done: cover property (extend_done);
   c_restart: cover property ($rose(auto_restart));
   c_burst: cover property ($rose(burst_mode));
   c_det_never: cover property (det_done && level.sel == bbls_pkg::SEL_NEVER);
endmodule

//--- inc/bbls_pkg.sv
// Constants, types and timing for the blanking and burst level select block.
package bbls_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int BLANK_TIME_US = 20_000;
   localparam int DETECT_TIME_US = 1_000;
   localparam int SPIKE_TIME_NS = 30_000;
   localparam int BLANK_CYC = BLANK_TIME_US * CLK_MHZ;
   localparam int DETECT_CYC = DETECT_TIME_US * CLK_MHZ;
   localparam int SPIKE_CYC = (SPIKE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam logic [8:0] EXT_TOTAL = 9'h100;
   localparam logic [15:0] DET_BOUND_0 = 16'h0008;
   localparam logic [15:0] DET_BOUND_1 = 16'h0040;
   localparam logic [15:0] DET_BOUND_2 = 16'h0100;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_COUNT = 4'h8;
   localparam int CTRL_EXTEND_BIT = 0;
   localparam logic CTRL_EXTEND_RESET = 1'b0;
   localparam logic [11:0] ENTRY_MV_0 = 12'h640;
   localparam logic [11:0] ENTRY_MV_1 = 12'h58C;
   localparam logic [11:0] ENTRY_MV_2 = 12'h4F6;
   localparam logic [11:0] CLIMIT_MV_0 = 12'h1C2;
   localparam logic [11:0] CLIMIT_MV_1 = 12'h172;
   localparam logic [11:0] CLIMIT_MV_2 = 12'h136;
   localparam logic [11:0] MV_NONE = 12'h000;
   localparam logic [1:0] SEL_NEVER = 2'h3;

   typedef enum logic [1:0] {
      EXT_IDLE = 2'b00,
      EXT_CHARGE = 2'b01,
      EXT_DISCHARGE = 2'b10,
      EXT_DONE = 2'b11
   } bbls_ext_state_type;

   typedef enum logic [1:0] {
      DET_WAIT = 2'b00,
      DET_CHARGE = 2'b01,
      DET_DISCHARGE = 2'b10,
      DET_DONE = 2'b11
   } bbls_det_state_type;

   typedef struct packed {
      logic overload_cmp;
      logic burst_entry_cmp;
      logic burst_exit_cmp;
      logic extend_upper_cmp;
      logic extend_lower_cmp;
      logic fb_upper_cmp;
      logic fb_lower_cmp;
   } bbls_cmp_type;

   typedef struct packed {
      logic extend_charge_sw;
      logic extend_discharge_sw;
      logic fb_discharge_sw;
   } bbls_sw_type;

   typedef struct packed {
      logic [1:0] sel;
      logic [11:0] burst_entry_threshold;
      logic [11:0] burst_climit;
   } bbls_level_type;
endpackage

//--- test/bbls_pin_model.sv
// Behavioural model of the extension and feedback capacitor pins.
`timescale 1ns/100ps
module bbls_pin_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire bbls_pkg::bbls_sw_type sw,
   input wire logic [5:0] ext_step,
   input wire logic [5:0] fb_step,
   output logic ext_up,
   output logic ext_lo,
   output logic fb_up,
   output logic fb_lo
);
   // Pin voltages are kept in tenths of a volt and clamp at the 5 V source.
   logic [6:0] ext_v;
   logic [6:0] fb_v;
   logic [6:0] ext_add;
   logic [6:0] fb_add;
   assign ext_add = ext_v + 7'(ext_step);
   assign fb_add = fb_v + 7'(fb_step);
   assign ext_up = ext_v >= 7'h2D;
   assign ext_lo = ext_v <= 7'h09;
   assign fb_up = fb_v >= 7'h2D;
   assign fb_lo = fb_v <= 7'h05;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ext_v <= 7'h00;
         fb_v <= 7'h00;
      end else begin
         if (sw.extend_charge_sw) begin
            ext_v <= (ext_add > 7'h32) ? 7'h32 : ext_add;
         end else if (sw.extend_discharge_sw) begin
            ext_v <= (ext_v < 7'(ext_step)) ? 7'h00 : ext_v - 7'(ext_step);
         end
         if (sw.fb_discharge_sw) begin
            fb_v <= (fb_v < 7'(fb_step)) ? 7'h00 : fb_v - 7'(fb_step);
         end else begin
            fb_v <= (fb_add > 7'h32) ? 7'h32 : fb_add;
         end
      end
   end
endmodule

//--- test/tb.sv
// Self-checking testbench of the blanking and burst level select block.
`timescale 1ns/100ps
module tb;
   localparam logic [15:0] B0 = 16'h0003;
   localparam logic [15:0] B1 = 16'h000C;
   localparam logic [15:0] B2 = 16'h0028;
   logic clock = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic ovl = 1'b0, b_in = 1'b0, b_out = 1'b0, vcc_on = 1'b1, protect_hold = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [5:0] fb_step = 6'h28;
   logic [5:0] steps [4] = '{6'h32, 6'h01, 6'h03, 6'h08};
   bbls_pkg::bbls_cmp_type cmp;
   bbls_pkg::bbls_sw_type sw;
   bbls_pkg::bbls_level_type level;
   logic e_up, e_lo, f_up, f_lo, ff, gate, ext_done, auto_rs, burst;
   logic [15:0] cnt;
   logic [1:0] sel_exp;
   logic [11:0] entry_tab [4];
   logic [11:0] climit_tab [4];
   int n_mismatch = 0, samples_checked = 0, cycles = 0;
   assign cmp = {ovl, b_in, b_out, e_up, e_lo, f_up, f_lo};
   always #20 clock = ~clock;
   bbls_core #(.BLANK_CYC(20'h00028), .DETECT_CYC(20'h000C8), .DET_BOUND_0(B0),
      .DET_BOUND_1(B1), .DET_BOUND_2(B2)) u_dut (.clock(clock), .arst_n(arst_n),
      .cmp(cmp), .vcc_on(vcc_on), .protect_hold(protect_hold), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .sw(sw), .level_detect_ff(ff),
      .protect_and_gate(gate), .extend_done(ext_done), .auto_restart(auto_rs),
      .burst_mode(burst), .level(level));
   bbls_pin_model u_model (.clock(clock), .arst_n(arst_n), .sw(sw), .ext_step(6'h12),
      .fb_step(fb_step), .ext_up(e_up), .ext_lo(e_lo), .fb_up(f_up), .fb_lo(f_lo));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wait_cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task do_reset(input logic hold);
      @(posedge clock);
      arst_n <= 1'b0;
      protect_hold <= hold;
      repeat (4) @(posedge clock);
      arst_n <= 1'b1;
   endtask
   task test_done;
      $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 12000) begin
         n_mismatch++;
         test_done();
      end
   end
   // ----------------------------------------
   // Test sequence.
   // ----------------------------------------
   initial begin
      entry_tab = '{bbls_pkg::ENTRY_MV_0, bbls_pkg::ENTRY_MV_1, bbls_pkg::ENTRY_MV_2,
         bbls_pkg::MV_NONE};
      climit_tab = '{bbls_pkg::CLIMIT_MV_0, bbls_pkg::CLIMIT_MV_1, bbls_pkg::CLIMIT_MV_2,
         bbls_pkg::MV_NONE};
      for (int i = 0; i < 4; i++) begin
         fb_step = steps[i];
         do_reset(i == 0);
         if (i == 0) begin
            wait_cyc(300);
            rd_reg(bbls_pkg::ADDR_COUNT, rv);
            chk(32'(rv[15:0]), 32'h0);
            @(posedge clock) protect_hold <= 1'b0;
         end
         wait_cyc(260);
         rd_reg(bbls_pkg::ADDR_COUNT, rv);
         cnt = rv[15:0];
         sel_exp = (cnt <= B0) ? 2'h0 : (cnt <= B1) ? 2'h1 : (cnt <= B2) ? 2'h2 : 2'h3;
         chk(32'(cnt != 16'h0000), 32'h1);
         chk(32'(level.sel), 32'(sel_exp));
         chk(32'(level.burst_entry_threshold), 32'(entry_tab[sel_exp]));
         chk(32'(level.burst_climit), 32'(climit_tab[sel_exp]));
         wait_cyc(100);
         rd_reg(bbls_pkg::ADDR_COUNT, rv);
         chk(32'(rv[15:0]), 32'(cnt));
         chk(32'(ff), 32'h0);
         chk(32'(sw.fb_discharge_sw), 32'h0);
      end
      @(posedge clock) b_in <= 1'b1;
      wait_cyc(30);
      @(posedge clock) b_in <= 1'b0;
      @(posedge clock) b_in <= 1'b1;
      wait_cyc(35);
      chk(32'(burst), 32'h0);
      wait_cyc(10);
      chk(32'(burst), 32'(sel_exp != bbls_pkg::SEL_NEVER));
      @(posedge clock) b_out <= 1'b1;
      @(posedge clock) b_out <= 1'b0;
      b_in <= 1'b0;
      wait_cyc(1);
      chk(32'(burst), 32'h0);
      rd_reg(bbls_pkg::ADDR_CTRL, rv);
      chk(rv, 32'h0);
      rd_reg(4'hC, rv);
      chk(rv, 32'h0);
      @(posedge clock) ovl <= 1'b1;
      wait_cyc(35);
      chk(32'(gate), 32'h0);
      wait_cyc(10);
      chk(32'(gate), 32'h1);
      chk(32'(sw.extend_charge_sw), 32'h0);
      @(posedge clock) ovl <= 1'b0;
      wait_cyc(1);
      chk(32'(gate), 32'h0);
      wr_reg(bbls_pkg::ADDR_CTRL, 32'h1);
      rd_reg(bbls_pkg::ADDR_STATUS, rv);
      chk(32'(rv[0]), 32'h1);
      @(posedge clock) ovl <= 1'b1;
      wait_cyc(45);
      chk(32'(gate), 32'h0);
      chk(32'(sw.extend_charge_sw | sw.extend_discharge_sw), 32'h1);
      for (int k = 0; k < 3000 && ext_done !== 1'b1; k++) wait_cyc(1);
      rd_reg(bbls_pkg::ADDR_COUNT, rv);
      chk(32'(rv[24:16]), 32'h100);
      chk(32'(ext_done), 32'h1);
      chk(32'(gate), 32'h1);
      wait_cyc(730);
      chk(32'(auto_rs), 32'h0);
      wait_cyc(25);
      chk(32'(auto_rs), 32'h1);
      rd_reg(bbls_pkg::ADDR_STATUS, rv);
      chk(rv, {24'h000000, 1'b1, sel_exp, 5'h0F});
      @(posedge clock) vcc_on <= 1'b0;
      ovl <= 1'b0;
      wait_cyc(2);
      chk(32'(auto_rs), 32'h0);
      @(posedge clock) vcc_on <= 1'b1;
      wait_cyc(300);
      rd_reg(bbls_pkg::ADDR_COUNT, rv);
      chk(32'(rv[15:0]), 32'(cnt));
      test_done();
   end
endmodule
